// ===== pkg/cbw_pkg.sv
/*
 cbw_pkg: offsets, lanes, reset values and field positions of the bridge window block.
 assumes configuration accesses arrive as aligned dwords with byte enables.
*/
`default_nettype none
package cbw_pkg;
	localparam logic [7:0]  CBW_OFS_SUB      = 8'h1a;
	localparam logic [7:0]  CBW_OFS_LAT      = 8'h1b;
	localparam logic [7:0]  CBW_OFS_MEMBASE0 = 8'h1c;
	localparam logic [7:0]  CBW_OFS_MEMBASE1 = 8'h24;
	localparam int          CBW_SUB_LANE     = 2;
	localparam int          CBW_LAT_LANE     = 3;
	localparam int          CBW_PRI_LANE     = 0;
	localparam int          CBW_SEC_LANE     = 1;
	localparam logic [7:0]  CBW_SUB_RST      = 8'h00;
	localparam logic [7:0]  CBW_LAT_RST      = 8'h00;
	localparam logic [19:0] CBW_BASE_RST     = 20'h00000;
	localparam logic [11:0] CBW_BASE_LOW     = 12'h000;
	localparam logic [7:0]  CBW_LAT_MIN_REC  = 8'h40;
	localparam int          CBW_BRG_PF0_BIT  = 8;
	localparam int          CBW_BRG_PF1_BIT  = 9;
	localparam int          CBW_MAX_FUNC     = 8;
endpackage
`default_nettype wire

// ===== rtl/cbw_lat_timer.sv
/*
 cbw_lat_timer: initiator latency counter for one card function.
 assumes frame_start pulses in the cycle the initiator asserts the frame, on this clock.
*/
`default_nettype none
module cbw_lat_timer (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] lat_val,
	input  wire logic       frame_start,
	input  wire logic       xfer_active,
	output logic            stop_q
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       run;
		logic       stop;
	} cbw_tmr_t;

	cbw_tmr_t st_q;
	cbw_tmr_t st_d;

	always_comb begin
		st_d = st_q;
		if (!xfer_active) begin
			st_d.run  = 1'b0;
			st_d.stop = 1'b0;
		end
		if (frame_start) begin
			st_d.cnt  = lat_val;
			st_d.run  = 1'b1;
			st_d.stop = (lat_val == 8'h00);
		end else if (st_q.run && xfer_active) begin
			if (st_q.cnt != 8'h00)
				st_d.cnt = st_q.cnt - 8'h01;
			// stop stays until the transfer ends; datapath ends after the next data phase
			if (st_q.cnt <= 8'h01)
				st_d.stop = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign stop_q = st_q.stop;

	property p_load;
		@(posedge clk) disable iff (!rst_n)
		frame_start |=> (st_q.cnt == $past(lat_val)) && st_q.run;
	endproperty
	a_load: assert property (p_load) else $error("timer not loaded at frame start");

	property p_expire;
		@(posedge clk) disable iff (!rst_n)
		st_q.run && xfer_active && !frame_start && st_q.cnt == 8'h01 |=> stop_q;
	endproperty
	a_expire: assert property (p_expire) else $error("stop missing at expiry");

	property p_no_early;
		@(posedge clk) disable iff (!rst_n)
		frame_start && lat_val > 8'h02 ##1 xfer_active && !frame_start |=> !stop_q;
	endproperty
	a_no_early: assert property (p_no_early) else $error("stop raised too early");
endmodule
`default_nettype wire

// ===== rtl/cbw_window_cfg.sv
/*
 cbw_window_cfg: subordinate bus number, latency timer and memory base registers
 per card function, config forward decision and memory window match.
 assumes all inputs come from logic on clk; limits and bridge control live elsewhere.
*/
`default_nettype none
// Function
// - 8-bit subordinate bus register, reset zero
// - combine bus numbers for config forwarding
// - separate subordinate register per function
// - 8-bit latency timer at next byte
// - counter starts when frame asserted
// - expiry ends transfer after next phase
// - base bounds windows in both directions
// - upper twenty base bits writable
// - low twelve base bits read zero
// - bridge control bits 8,9 select prefetch
// - zero base and limit disables window
module cbw_window_cfg #(
	parameter int NUM_FUNC = 2,
	parameter int FW       = (NUM_FUNC > 1) ? $clog2(NUM_FUNC) : 1
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 cfg_wr,
	input  wire logic                 cfg_rd,
	input  wire logic [FW-1:0]        cfg_func,
	input  wire logic [7:0]           cfg_addr,
	input  wire logic [3:0]           cfg_be,
	input  wire logic [31:0]          cfg_wdata,
	output logic [31:0]               cfg_rdata_q,
	output logic                      cfg_rvalid_q,
	input  wire logic [7:0]           pri_bus,
	input  wire logic [7:0]           sec_bus,
	input  wire logic [7:0]           cfg_bus,
	output logic                      cfg_fwd_q,
	output logic                      cfg_fwd_t0_q,
	input  wire logic [FW-1:0]        mem_func,
	input  wire logic [31:0]          mem_addr,
	input  wire logic                 mem_from_cb,
	input  wire logic [31:0]          mem_lim0,
	input  wire logic [31:0]          mem_lim1,
	input  wire logic [15:0]          brg_ctrl,
	output logic [1:0]                win_hit_q,
	output logic [1:0]                win_pf_q,
	output logic                      mem_claim_q,
	input  wire logic [NUM_FUNC-1:0]  cb_frame_start,
	input  wire logic [NUM_FUNC-1:0]  cb_xfer_active,
	output logic [NUM_FUNC-1:0]       cb_stop_q
);
	// refused while elaborating, before any cycle runs
	if (NUM_FUNC < 1 || NUM_FUNC > cbw_pkg::CBW_MAX_FUNC
	    || FW < $clog2(NUM_FUNC)) begin : g_bad_cfg
		$error("NUM_FUNC out of range");
	end

	typedef struct packed {
		logic [NUM_FUNC-1:0][7:0]       sub;
		logic [NUM_FUNC-1:0][7:0]       lat;
		logic [NUM_FUNC-1:0][1:0][19:0] base;
		logic [31:0]                    rdata;
		logic                           rvalid;
		logic                           fwd;
		logic                           fwd_t0;
		logic [1:0]                     hit;
		logic [1:0]                     pf;
		logic                           claim;
	} cbw_state_t;

	cbw_state_t st_q;
	cbw_state_t st_d;

	logic           fok;
	logic           mok;
	logic [FW-1:0]  cf;
	logic [FW-1:0]  mf;
	wire  [1:0]     en;
	wire  [1:0]     inwin;
	logic [19:0]    pg;

	// out-of-range function numbers fall back to function 0 and never write
	assign fok   = (32'(cfg_func) < NUM_FUNC);
	assign mok   = (32'(mem_func) < NUM_FUNC);
	assign cf    = fok ? cfg_func : '0;
	assign mf    = mok ? mem_func : '0;
	assign pg    = mem_addr[31:12];
	assign en[0] = (st_q.base[mf][0] != 20'h0) || (mem_lim0[31:12] != 20'h0);
	assign en[1] = (st_q.base[mf][1] != 20'h0) || (mem_lim1[31:12] != 20'h0);
	assign inwin[0] = en[0] && pg >= st_q.base[mf][0] && pg <= mem_lim0[31:12];
	assign inwin[1] = en[1] && pg >= st_q.base[mf][1] && pg <= mem_lim1[31:12];

	always_comb begin
		st_d        = st_q;
		st_d.rvalid = cfg_rd;
		if (cfg_wr && fok) begin
			if (cfg_addr[7:2] == cbw_pkg::CBW_OFS_SUB[7:2]) begin
				if (cfg_be[cbw_pkg::CBW_SUB_LANE])
					st_d.sub[cf] = cfg_wdata[8*cbw_pkg::CBW_SUB_LANE +: 8];
				if (cfg_be[cbw_pkg::CBW_LAT_LANE])
					st_d.lat[cf] = cfg_wdata[8*cbw_pkg::CBW_LAT_LANE +: 8];
			end
			for (int w = 0; w < 2; w++) begin
				if (cfg_addr == (w == 0 ? cbw_pkg::CBW_OFS_MEMBASE0
				                        : cbw_pkg::CBW_OFS_MEMBASE1)) begin
					// lane 0 and the low nibble of lane 1 are dropped
					if (cfg_be[3])
						st_d.base[cf][w][19:12] = cfg_wdata[31:24];
					if (cfg_be[2])
						st_d.base[cf][w][11:4] = cfg_wdata[23:16];
					if (cfg_be[1])
						st_d.base[cf][w][3:0] = cfg_wdata[15:12];
				end
			end
		end
		if (cfg_rd) begin
			st_d.rdata = 32'h0;
			if (fok) begin
				if (cfg_addr[7:2] == cbw_pkg::CBW_OFS_SUB[7:2])
					st_d.rdata = {st_q.lat[cf], st_q.sub[cf], sec_bus, pri_bus};
				else if (cfg_addr == cbw_pkg::CBW_OFS_MEMBASE0)
					st_d.rdata = {st_q.base[cf][0], cbw_pkg::CBW_BASE_LOW};
				else if (cfg_addr == cbw_pkg::CBW_OFS_MEMBASE1)
					st_d.rdata = {st_q.base[cf][1], cbw_pkg::CBW_BASE_LOW};
			end
		end
		// config cycles for the primary bus itself stay local
		st_d.fwd    = fok && cfg_bus != pri_bus && cfg_bus >= sec_bus
		              && cfg_bus <= st_q.sub[cf];
		st_d.fwd_t0 = fok && cfg_bus != pri_bus && cfg_bus == sec_bus;
		st_d.hit    = mok ? inwin : 2'b00;
		// from the card side, traffic outside every window goes upstream
		st_d.claim  = mok && (mem_from_cb ? ~|inwin : |inwin);
		st_d.pf     = {brg_ctrl[cbw_pkg::CBW_BRG_PF1_BIT],
		               brg_ctrl[cbw_pkg::CBW_BRG_PF0_BIT]};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			for (int f = 0; f < NUM_FUNC; f++) begin
				st_q.sub[f]     <= cbw_pkg::CBW_SUB_RST;
				st_q.lat[f]     <= cbw_pkg::CBW_LAT_RST;
				st_q.base[f][0] <= cbw_pkg::CBW_BASE_RST;
				st_q.base[f][1] <= cbw_pkg::CBW_BASE_RST;
			end
		end else begin
			st_q <= st_d;
		end
	end

	assign cfg_rdata_q  = st_q.rdata;
	assign cfg_rvalid_q = st_q.rvalid;
	assign cfg_fwd_q    = st_q.fwd;
	assign cfg_fwd_t0_q = st_q.fwd_t0;
	assign win_hit_q    = st_q.hit;
	assign win_pf_q     = st_q.pf;
	assign mem_claim_q  = st_q.claim;

	// one counter per function; a zero timer ends each transfer after its first phase
	for (genvar f = 0; f < NUM_FUNC; f++) begin : g_tmr
		cbw_lat_timer u_tmr (
			.clk         (clk),
			.rst_n       (rst_n),
			.lat_val     (st_q.lat[f]),
			.frame_start (cb_frame_start[f]),
			.xfer_active (cb_xfer_active[f]),
			.stop_q      (cb_stop_q[f])
		);
	end

	property p_sub_wr;
		@(posedge clk) disable iff (!rst_n)
		cfg_wr && fok && cfg_addr[7:2] == cbw_pkg::CBW_OFS_SUB[7:2]
		&& cfg_be[cbw_pkg::CBW_SUB_LANE]
		|=> st_q.sub[$past(cf)] == $past(cfg_wdata[23:16]);
	endproperty
	a_sub_wr: assert property (p_sub_wr) else $error("subordinate write lost");

	property p_lat_wr;
		@(posedge clk) disable iff (!rst_n)
		cfg_wr && fok && cfg_addr[7:2] == cbw_pkg::CBW_OFS_LAT[7:2]
		&& cfg_be[cbw_pkg::CBW_LAT_LANE] ##1 cfg_rd && !cfg_wr && cfg_func == $past(cfg_func)
		&& cfg_addr[7:2] == cbw_pkg::CBW_OFS_LAT[7:2]
		|=> cfg_rdata_q[31:24] == $past(cfg_wdata[31:24], 2);
	endproperty
	a_lat_wr: assert property (p_lat_wr) else $error("latency timer readback wrong");

	property p_func_iso;
		@(posedge clk) disable iff (!rst_n)
		NUM_FUNC > 1 && cfg_wr && cfg_func == '0 |=> $stable(st_q.sub[NUM_FUNC-1]);
	endproperty
	a_func_iso: assert property (p_func_iso) else $error("write leaked to other function");

	property p_base_wr;
		@(posedge clk) disable iff (!rst_n)
		cfg_wr && fok && cfg_addr == cbw_pkg::CBW_OFS_MEMBASE0 && cfg_be == 4'hf
		|=> st_q.base[$past(cf)][0] == $past(cfg_wdata[31:12]);
	endproperty
	a_base_wr: assert property (p_base_wr) else $error("base upper bits not written");

	property p_base_low;
		@(posedge clk) disable iff (!rst_n)
		cfg_rd && (cfg_addr == cbw_pkg::CBW_OFS_MEMBASE0
		|| cfg_addr == cbw_pkg::CBW_OFS_MEMBASE1) |=> cfg_rdata_q[11:0] == 12'h000;
	endproperty
	a_base_low: assert property (p_base_low) else $error("base low bits not zero");

	property p_fwd;
		@(posedge clk) disable iff (!rst_n)
		fok && cfg_bus != pri_bus && cfg_bus >= sec_bus && cfg_bus <= st_q.sub[cf]
		|=> cfg_fwd_q;
	endproperty
	a_fwd: assert property (p_fwd) else $error("in-range config cycle not forwarded");

	property p_no_fwd;
		@(posedge clk) disable iff (!rst_n)
		(cfg_bus > st_q.sub[cf] || cfg_bus < sec_bus) |=> !cfg_fwd_q;
	endproperty
	a_no_fwd: assert property (p_no_fwd) else $error("out-of-range cycle forwarded");

	property p_pf;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> win_pf_q == $past(brg_ctrl[9:8]);
	endproperty
	a_pf: assert property (p_pf) else $error("prefetch select mismatch");

	property p_disabled;
		@(posedge clk) disable iff (!rst_n)
		st_q.base[mf][0] == 20'h0 && mem_lim0[31:12] == 20'h0 |=> !win_hit_q[0];
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled window hit");

	property p_claim;
		@(posedge clk) disable iff (!rst_n)
		mok && !mem_from_cb && en[0] && pg >= st_q.base[mf][0] && pg <= mem_lim0[31:12]
		|=> mem_claim_q && win_hit_q[0];
	endproperty
	a_claim: assert property (p_claim) else $error("window address not claimed");
endmodule
`default_nettype wire

// ===== testbench/cbw_card_model.sv
/*
 cbw_card_model: card-side initiator stand-in for one function.
 assumes go is a one-cycle request from the bench and stop comes from the latency timer.
*/
`default_nettype none
module cbw_card_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic go,
	input  wire logic stop,
	output logic      frame_start,
	output logic      xfer_active
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_start <= 1'b0;
			xfer_active <= 1'b0;
		end else begin
			// frame pulse marks the first cycle of the transfer
			frame_start <= go & ~xfer_active;
			if (go & ~xfer_active) begin
				xfer_active <= 1'b1;
			end else if (stop) begin
				// one last data phase, then let go of the bus
				xfer_active <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/cbw_window_cfg_tb.sv
/*
 cbw_window_cfg_tb: register, forwarding, window and latency timer tests.
 assumes cbw_card_model drives function 0; function 1 has no initiator traffic.
*/
`default_nettype none
module cbw_window_cfg_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, go = 1'b0;
	logic [0:0]  cfg_func = 1'b0, mem_func = 1'b0;
	logic [7:0]  cfg_addr = 8'h00, pri_bus = 8'h01, sec_bus = 8'h02, cfg_bus = 8'h00;
	logic [3:0]  cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0, mem_addr = 32'h0;
	logic [31:0] mem_lim0 = 32'h0001_f000, mem_lim1 = 32'h0;
	logic        mem_from_cb = 1'b0;
	logic [15:0] brg_ctrl = 16'h0200;
	logic [31:0] cfg_rdata_q;
	logic        cfg_rvalid_q, cfg_fwd_q, cfg_fwd_t0_q, mem_claim_q, fs, act, ec;
	logic [1:0]  win_hit_q, win_pf_q, cb_stop_q, eh;
	logic [7:0]  bus_t [5] = '{8'h01, 8'h02, 8'h05, 8'h07, 8'h08};
	logic [4:0]  fwd_e = 5'b01110;
	logic [35:0] win_t [5] = '{36'h00010800_3, 36'h0, 36'h0001ffff_a, 36'h00020000_9,
		36'h0000ffff_0};
	logic [7:0]  lat_t [4] = '{8'h00, 8'h01, 8'h03, 8'h40};
	int          n_fail = 0, checked = 0, cyc = 0;

	always #5 clk = ~clk;

	cbw_window_cfg #(.NUM_FUNC(2)) i_dut (
		.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_func(cfg_func),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .pri_bus(pri_bus),
		.sec_bus(sec_bus), .cfg_bus(cfg_bus), .cfg_fwd_q(cfg_fwd_q),
		.cfg_fwd_t0_q(cfg_fwd_t0_q), .mem_func(mem_func), .mem_addr(mem_addr),
		.mem_from_cb(mem_from_cb), .mem_lim0(mem_lim0), .mem_lim1(mem_lim1),
		.brg_ctrl(brg_ctrl), .win_hit_q(win_hit_q), .win_pf_q(win_pf_q),
		.mem_claim_q(mem_claim_q), .cb_frame_start({1'b0, fs}),
		.cb_xfer_active({1'b0, act}), .cb_stop_q(cb_stop_q));

	cbw_card_model i_card (
		.clk(clk), .rst_n(rst_n), .go(go), .stop(cb_stop_q[0]),
		.frame_start(fs), .xfer_active(act));

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [0:0] f, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		cfg_func = f;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask

	task automatic rd(input logic [0:0] f, input logic [7:0] a, input logic [31:0] e);
		cfg_func = f;
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(negedge clk);
		cfg_rd = 1'b0;
		chk("rvalid", 32'h1, {31'h0, cfg_rvalid_q});
		chk("rdata", e, cfg_rdata_q);
		// idle edge so back-to-back reads never retoggle the strobe in one step
		@(negedge clk);
	endtask

	// counts negedges from the request until stop shows
	task automatic tmr(input logic [7:0] n);
		int k;
		wr(1'b0, 8'h18, 4'h8, {n, 24'h0});
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		k = 0;
		while (cb_stop_q[0] !== 1'b1 && k < 300) begin
			@(negedge clk);
			k++;
		end
		// a zero timer expires at the frame edge itself
		chk("stop_lat", (n == 8'h00) ? 32'h1 : {24'h0, n} + 32'h1, k);
		repeat (4) @(negedge clk);
		chk("stop_clr", 32'h0, {31'h0, cb_stop_q[0]});
		chk("stop1", 32'h0, {31'h0, cb_stop_q[1]});
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// whole run needs about 130 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		rd(1'b0, 8'h18, 32'h0000_0201);
		wr(1'b0, 8'h18, 4'hc, 32'hff40_5555);
		rd(1'b0, 8'h18, 32'hff40_0201);
		rd(1'b1, 8'h18, 32'h0000_0201);
		wr(1'b0, 8'h18, 4'h4, 32'h0007_0000);
		for (int i = 0; i < 5; i++) begin
			cfg_bus = bus_t[i];
			@(negedge clk);
			chk("fwd", {31'h0, fwd_e[i]}, {31'h0, cfg_fwd_q});
			chk("fwd_t0", {31'h0, i == 1}, {31'h0, cfg_fwd_t0_q});
		end
		rd(1'b0, 8'h1c, 32'h0);
		wr(1'b0, 8'h1c, 4'hf, 32'hffff_ffff);
		rd(1'b0, 8'h1c, 32'hffff_f000);
		wr(1'b0, 8'h1c, 4'hf, 32'h0001_0abc);
		rd(1'b0, 8'h1c, 32'h0001_0000);
		rd(1'b0, 8'h24, 32'h0);
		rd(1'b0, 8'h20, 32'h0);
		for (int i = 0; i < 5; i++) begin
			{mem_addr, mem_from_cb, eh, ec} = win_t[i];
			@(negedge clk);
			chk("win_hit", {30'h0, eh}, {30'h0, win_hit_q});
			chk("claim", {31'h0, ec}, {31'h0, mem_claim_q});
			chk("win_pf", 32'h2, {30'h0, win_pf_q});
		end
		for (int i = 0; i < 4; i++) begin
			tmr(lat_t[i]);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
